/* File: hdl/fwe_consts.vh */
// Purpose: shared constants of the serial memory command decoder
// Assumes: included by its bare name, definitions only
// Notes:   opcodes are fixed here; only the buffer depth and its pointer width are overridable, through parameters
`ifndef FWE_CONSTS_VH
`define FWE_CONSTS_VH

// Command bytes
`define FWE_OP_PERMIT     8'h06
`define FWE_OP_FORBID     8'h04
`define FWE_OP_STAT_RD    8'h05
`define FWE_OP_STAT_WR    8'h01
`define FWE_OP_MEM_MASK   8'hf7
`define FWE_OP_MEM_WR     8'h02
`define FWE_OP_MEM_RD     8'h03
`define FWE_OP_ABIT       3

// Status byte layout
`define FWE_ST_WPL        1
`define FWE_ST_PROT_LO    2
`define FWE_ST_PROT_HI    3
`define FWE_ST_RST        8'h00

// Array shape and write buffer
`define FWE_ADDR_W        9
`define FWE_FIFO_DEPTH    8
`define FWE_FIFO_AW       3

`endif

/* File: hdl/fwe_decode.v */
// Purpose: serial command decoder and write permit latch of a 512 byte
//          ferroelectric memory, with status byte and write buffer
// Assumes: serial clock, select and data arrive from outside and are
//          synchronised here; array read data is valid one cycle after
//          mem_rd_addr_q changes
// Notes:   serial modes 0 and 3; the upper half write keeps the latch set
//          while KEEP_ON_UPPER is 1, as the production silicon does
`timescale 1ns/1ps
`include "fwe_consts.vh"
module fwe_decode #(
  parameter KEEP_ON_UPPER = 1,
  parameter FIFO_DEPTH    = `FWE_FIFO_DEPTH,
  parameter FIFO_AW       = `FWE_FIFO_AW
) (
  input  wire        clk,             // 200 MHz system clock
  input  wire        rst_b,           // Synchronous reset, low
  input  wire        sck,             // Serial clock pin
  input  wire        cs_b,            // Chip select pin, low
  input  wire        mosi,            // Serial data in pin
  output reg         miso_q,          // Serial data out
  output reg         miso_oe_q,       // Data out enable, high drives
  output reg  [8:0]  mem_rd_addr_q,   // Array read address
  input  wire [7:0]  mem_rd_data,     // Array read data
  output wire        mem_wr_valid_q,  // Array write offered
  input  wire        mem_wr_ready,    // Array takes the write
  output wire [8:0]  mem_wr_addr_q,   // Array write address
  output wire [7:0]  mem_wr_data_q,   // Array write data
  output reg         write_permit_q,  // Write permit latch
  output reg  [1:0]  protect_sel_q,   // Protect selects high, low
  output reg         wr_overrun_q     // Write byte lost in frame
);

  // Frame states
  localparam ST_IDLE    = 3'd0;
  localparam ST_CMD     = 3'd1;
  localparam ST_ADDR    = 3'd2;
  localparam ST_DATA_WR = 3'd3;
  localparam ST_DATA_RD = 3'd4;
  localparam ST_STAT_RD = 3'd5;
  localparam ST_STAT_WR = 3'd6;
  localparam ST_IGNORE  = 3'd7;

  localparam AW = `FWE_ADDR_W;
  localparam WW = AW + 8;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds stage two only
  reg        sck_s1_q;
  reg        sck_s2_q;
  reg        sck_s3_q;
  reg        cs_s1_q;
  reg        cs_s2_q;
  reg        cs_s3_q;
  reg        mosi_s1_q;
  reg        mosi_s2_q;

  always @(posedge clk) begin
    if (!rst_b) begin
      sck_s1_q  <= 1'b0;
      sck_s2_q  <= 1'b0;
      sck_s3_q  <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sck_s1_q  <= sck;
      sck_s2_q  <= sck_s1_q;
      sck_s3_q  <= sck_s2_q;
      cs_s1_q   <= cs_b;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      mosi_s1_q <= mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame state
  reg [2:0]    state_q;
  reg [2:0]    bit_cnt_q;
  reg [6:0]    rx_sh_q;
  reg [7:0]    opc_q;
  reg [AW-1:0] addr_q;
  reg [7:0]    tx_sh_q;
  reg          wrote_q;
  reg          pend_q;
  reg [WW-1:0] pend_word_q;

  wire       frame     = ~cs_s2_q;
  wire       cs_fall   = cs_s3_q & ~cs_s2_q;
  wire       cs_rise   = ~cs_s3_q & cs_s2_q;
  wire       sck_rise  = frame & ~sck_s3_q & sck_s2_q;
  wire       sck_fall  = frame & sck_s3_q & ~sck_s2_q;
  wire       byte_done = sck_rise & (bit_cnt_q == 3'd7);
  wire [7:0] rx_byte   = {rx_sh_q, mosi_s2_q};

  // Memory opcodes are matched with bit 3 masked off, which is the top address bit
  wire is_mem_wr = (rx_byte & `FWE_OP_MEM_MASK) == `FWE_OP_MEM_WR;
  wire is_mem_rd = (rx_byte & `FWE_OP_MEM_MASK) == `FWE_OP_MEM_RD;

  // Accepted data byte of a memory write
  wire new_wr = byte_done & (state_q == ST_DATA_WR) & write_permit_q;

  // Upper half writes leave the latch standing on this silicon
  wire keep_latch = (KEEP_ON_UPPER != 0) & opc_q[`FWE_OP_ABIT];

  ////////////////////////////////////////////////////////////////////////
  // Status byte as read back; undefined bits stay zero
  reg [7:0] status_byte;

  always @* begin
    status_byte                  = `FWE_ST_RST;
    status_byte[`FWE_ST_WPL]     = write_permit_q;
    status_byte[`FWE_ST_PROT_LO] = protect_sel_q[0];
    status_byte[`FWE_ST_PROT_HI] = protect_sel_q[1];
  end

  // Byte to send next, chosen by the phase of the frame
  reg [7:0] tx_next;

  always @* begin
    case (state_q)
      ST_STAT_RD: tx_next = status_byte;
      ST_DATA_RD: tx_next = mem_rd_data;
      default:    tx_next = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode, address and bit counting
  always @(posedge clk) begin
    if (!rst_b) begin
      state_q       <= ST_IDLE;
      bit_cnt_q     <= 3'd0;
      rx_sh_q       <= 7'h00;
      opc_q         <= 8'h00;
      addr_q        <= {AW{1'b0}};
      mem_rd_addr_q <= {AW{1'b0}};
      wrote_q       <= 1'b0;
      protect_sel_q <= 2'h0;
    end else if (cs_fall) begin
      state_q   <= ST_CMD;
      bit_cnt_q <= 3'd0;
      wrote_q   <= 1'b0;
    end else if (cs_rise) begin
      state_q <= ST_IDLE;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      rx_sh_q   <= rx_byte[6:0];
      if (byte_done) begin
        case (state_q)
          ST_CMD: begin
            opc_q <= rx_byte;
            if (is_mem_wr || is_mem_rd) begin
              state_q <= ST_ADDR;
            end else if (rx_byte == `FWE_OP_STAT_RD) begin
              state_q <= ST_STAT_RD;
            end else if (rx_byte == `FWE_OP_STAT_WR) begin
              state_q <= ST_STAT_WR;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            // Ninth bit comes from the command, eight from this byte
            addr_q        <= {opc_q[`FWE_OP_ABIT], rx_byte};
            mem_rd_addr_q <= {opc_q[`FWE_OP_ABIT], rx_byte};
            state_q       <= opc_q[0] ? ST_DATA_RD : ST_DATA_WR;
          end
          ST_DATA_RD: begin
            addr_q        <= addr_q + 1'b1;
            mem_rd_addr_q <= addr_q + 1'b1;
          end
          ST_DATA_WR: begin
            addr_q <= addr_q + 1'b1;
            if (write_permit_q) begin
              wrote_q <= 1'b1;
            end
          end
          ST_STAT_WR: begin
            // Only the protect selects take a written value
            if (write_permit_q) begin
              protect_sel_q[0] <= rx_byte[`FWE_ST_PROT_LO];
              protect_sel_q[1] <= rx_byte[`FWE_ST_PROT_HI];
              wrote_q          <= 1'b1;
            end
            state_q <= ST_IGNORE;
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write permit latch; only commands and write completion touch it
  always @(posedge clk) begin
    if (!rst_b) begin
      write_permit_q <= 1'b0;
    end else if (byte_done && state_q == ST_CMD && rx_byte == `FWE_OP_PERMIT) begin
      write_permit_q <= 1'b1;
    end else if (byte_done && state_q == ST_CMD && rx_byte == `FWE_OP_FORBID) begin
      write_permit_q <= 1'b0;
    end else if (cs_rise && wrote_q && !keep_latch) begin
      write_permit_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial data out; mode 0 needs the first bit before any clock edge
  always @(posedge clk) begin
    if (!rst_b) begin
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
      tx_sh_q   <= 8'h00;
    end else begin
      miso_oe_q <= frame & (state_q == ST_STAT_RD || state_q == ST_DATA_RD);
      if (cs_fall || cs_rise) begin
        miso_q  <= 1'b0;
        tx_sh_q <= 8'h00;
      end else if (sck_fall) begin
        if (bit_cnt_q == 3'd0) begin
          miso_q  <= tx_next[7];
          tx_sh_q <= {tx_next[6:0], 1'b0};
        end else begin
          miso_q  <= tx_sh_q[7];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte hand-off toward the buffer; one word may wait for room
  wire fifo_in_ready;

  always @(posedge clk) begin
    if (!rst_b) begin
      pend_q      <= 1'b0;
      pend_word_q <= {WW{1'b0}};
    end else if (new_wr && (!pend_q || fifo_in_ready)) begin
      pend_q      <= 1'b1;
      pend_word_q <= {addr_q, rx_byte};
    end else if (fifo_in_ready) begin
      pend_q <= 1'b0;
    end
  end

  // Lost byte flag; a loss in the clearing cycle still counts
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_overrun_q <= 1'b0;
    end else if (new_wr && pend_q && !fifo_in_ready) begin
      wr_overrun_q <= 1'b1;
    end else if (cs_fall) begin
      wr_overrun_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write buffer; array back-pressure fills it
  wire [WW-1:0] fifo_out;

  fwe_fifo #(
    .W  (WW),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk         (clk),
    .rst_b       (rst_b),
    .in_valid    (pend_q),
    .in_ready    (fifo_in_ready),
    .in_data     (pend_word_q),
    .out_valid_q (mem_wr_valid_q),
    .out_ready   (mem_wr_ready),
    .out_data_q  (fifo_out)
  );

  assign mem_wr_addr_q = fifo_out[WW-1:8];
  assign mem_wr_data_q = fifo_out[7:0];

endmodule

/* File: hdl/fwe_fifo.v */
// Purpose: small write buffer between the serial decoder and the array
// Assumes: one clock, synchronous active low reset
// Notes:   output side is registered; in_ready drops when full
`timescale 1ns/1ps
module fwe_fifo #(
  parameter W  = 17,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         clk,        // System clock
  input  wire         rst_b,      // Synchronous reset, low
  input  wire         in_valid,   // Word offered
  output wire         in_ready,   // Room for a word
  input  wire [W-1:0] in_data,    // Word in
  output reg          out_valid_q, // Word held at output
  input  wire         out_ready,  // Drain side takes word
  output reg  [W-1:0] out_data_q  // Word out
);

  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // Output stage refills whenever it is empty or being taken
  assign in_ready = (cnt_q != D[AW:0]);
  assign push     = in_valid & in_ready;
  assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  ////////////////////////////////////////////////////////////////////////
  // Storage, one flop row per entry
  genvar gi;
  generate
    for (gi = 0; gi < D; gi = gi + 1) begin : g_ent
      // Entry index at pointer width; a genvar takes no part-select
      localparam [AW-1:0] IDX = gi;
      always @(posedge clk) begin
        if (push && wp_q == IDX) begin
          mem_q[gi] <= in_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pointers, count and output register
  always @(posedge clk) begin
    if (!rst_b) begin
      wp_q        <= {AW{1'b0}};
      rp_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {W{1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q       <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
        out_data_q <= mem_q[rp_q];
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (pop) begin
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/fwe_decode_props.sv */
// Purpose: port level assertions for the serial command decoder
// Assumes: bound to fwe_decode, one clock domain
// Notes:   latch timing is judged against the select pin as seen
`timescale 1ns/1ps
module fwe_decode_props (
  input wire logic       clk,            // System clock
  input wire logic       rst_b,          // Reset, low
  input wire logic       cs_b,           // Select pin
  input wire logic       miso_oe_q,      // Data out enable
  input wire logic [8:0] mem_rd_addr_q,  // Read address
  input wire logic       mem_wr_valid_q, // Write offered
  input wire logic       mem_wr_ready,   // Write taken
  input wire logic [8:0] mem_wr_addr_q,  // Write address
  input wire logic [7:0] mem_wr_data_q,  // Write data
  input wire logic       write_permit_q, // Permit latch
  input wire logic [1:0] protect_sel_q,  // Protect selects
  input wire logic       wr_overrun_q    // Lost byte flag
);
  logic lo_wr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////
  // Lower half write seen in this frame; upper half ones keep the latch
  always @(posedge clk)
    if (!rst_b || $fell(cs_b)) lo_wr_q <= 1'b0;
    else if (mem_wr_valid_q && !mem_wr_addr_q[8]) lo_wr_q <= 1'b1;

  a_reset_latch_off : assert property ($rose(rst_b) |-> !write_permit_q && protect_sel_q == 2'b00)
    else $error("latch or protect set after reset");
  a_reset_out_idle : assert property ($rose(rst_b) |-> !miso_oe_q && !mem_wr_valid_q && !wr_overrun_q)
    else $error("outputs busy after reset");
  a_write_needs_latch : assert property ($rose(mem_wr_valid_q) |-> write_permit_q)
    else $error("array write offered with latch clear");
  a_word_held : assert property (mem_wr_valid_q && !mem_wr_ready |=> mem_wr_valid_q
    && $stable(mem_wr_addr_q) && $stable(mem_wr_data_q))
    else $error("write word changed while stalled");
  a_protect_needs_latch : assert property ($changed(protect_sel_q) |-> write_permit_q)
    else $error("protect selects changed with latch clear");
  a_rd_addr_framed : assert property ($changed(mem_rd_addr_q) |-> !cs_b)
    else $error("read address moved outside a frame");
  a_latch_idle_still : assert property (cs_b [*8] |=> $stable(write_permit_q))
    else $error("latch moved while deselected");
  a_oe_idle_off : assert property (cs_b [*6] |-> !miso_oe_q)
    else $error("data out driven while deselected");
  a_overrun_cleared : assert property ($fell(cs_b) |-> ##[1:6] !wr_overrun_q)
    else $error("overrun flag kept into a new frame");
  a_lower_clears : assert property ($rose(cs_b) && lo_wr_q |-> ##[1:8] !write_permit_q)
    else $error("latch kept after lower half write");
endmodule

bind fwe_decode fwe_decode_props u_props (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .miso_oe_q(miso_oe_q),
  .mem_rd_addr_q(mem_rd_addr_q), .mem_wr_valid_q(mem_wr_valid_q), .mem_wr_ready(mem_wr_ready),
  .mem_wr_addr_q(mem_wr_addr_q), .mem_wr_data_q(mem_wr_data_q), .write_permit_q(write_permit_q),
  .protect_sel_q(protect_sel_q), .wr_overrun_q(wr_overrun_q));

/* File: tb/fwe_host.sv */
// Purpose: serial host model driving the decoder link in mode 0
// Assumes: called from the bench, one frame at a time
// Notes:   serial clock stands low outside frames; released data toggles
`timescale 1ns/1ps
module fwe_host (
  input  wire logic clk,  // System clock
  output logic      sck,  // Serial clock, idle low
  output logic      cs_b, // Select, low
  output logic      mosi, // Data to device
  input  wire logic miso  // Data from device
);
  // Idle link at time zero
  initial begin
    sck  = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Eight clk per half bit gives the 80 ns link period
  task automatic frame(input logic [7:0] tx [0:15], input int n, output logic [7:0] rx);
    @(posedge clk) cs_b <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        @(posedge clk) mosi <= tx[i][b];
        repeat (7) @(posedge clk);
        sck <= 1'b1;
        rx[b] = miso;
        repeat (8) @(posedge clk);
        sck <= 1'b0;
      end
    end
    repeat (8) @(posedge clk);
    cs_b <= 1'b1;
    mosi <= ~mosi;
    repeat (16) @(posedge clk);
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self checking bench for the serial command decoder
// Assumes: host model drives the link, bench models the array
// Notes:   array ready is random, so writes are stalled at times
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst_b = 1'b0, mem_wr_ready = 1'b0, stall = 1'b0, lax = 1'b0;
  logic [7:0]  mem_rd_data = 8'h00, rx;
  logic [7:0]  tx [0:15];
  logic [7:0]  mem [0:511];
  logic [16:0] wq [$];
  int          bad_count = 0, n_compared = 0, cyc = 0;
  wire         sck, cs_b, mosi, miso_q, miso_oe_q, mem_wr_valid_q, write_permit_q, wr_overrun_q;
  wire [8:0]   mem_rd_addr_q, mem_wr_addr_q;
  wire [7:0]   mem_wr_data_q;
  wire [1:0]   protect_sel_q;
  wire         miso = miso_oe_q ? miso_q : 1'bz;

  always #2.5 clk = ~clk;
  fwe_decode u_dut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .mosi(mosi), .miso_q(miso_q),
    .miso_oe_q(miso_oe_q), .mem_rd_addr_q(mem_rd_addr_q), .mem_rd_data(mem_rd_data),
    .mem_wr_valid_q(mem_wr_valid_q), .mem_wr_ready(mem_wr_ready), .mem_wr_addr_q(mem_wr_addr_q),
    .mem_wr_data_q(mem_wr_data_q), .write_permit_q(write_permit_q), .protect_sel_q(protect_sel_q),
    .wr_overrun_q(wr_overrun_q));
  fwe_host u_host (.clk(clk), .sck(sck), .cs_b(cs_b), .mosi(mosi), .miso(miso));

  ////////////////////////////////////////////////////////////
  // Array model with random stalls; timeout cuts a hang short
  always @(posedge clk) begin
    mem_wr_ready <= !stall && ($urandom % 3 != 0);
    mem_rd_data  <= mem[mem_rd_addr_q];
    cyc          <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  // Oldest note is taken for each word the array accepts
  always @(posedge clk)
    if (rst_b && mem_wr_valid_q && mem_wr_ready) begin
      mem[mem_wr_addr_q] <= mem_wr_data_q;
      if (wq.size() != 0) check({mem_wr_addr_q, mem_wr_data_q}, wq.pop_front());
      else if (!lax) begin
        bad_count++;
        $display("[ERR] %0t unexpected array write", $time);
      end
    end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd1(input logic [7:0] op);
    tx[0] = op;
    u_host.frame(tx, 1, rx);
  endtask
  task automatic stat(input logic [7:0] exp);
    tx[0] = 8'h05;
    tx[1] = 8'h00;
    u_host.frame(tx, 2, rx);
    check(17'(rx), 17'(exp));
  endtask
  task automatic wst(input logic [7:0] d);
    tx[0] = 8'h01;
    tx[1] = d;
    u_host.frame(tx, 2, rx);
  endtask
  // Command byte carries the ninth address bit
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic ok);
    tx[0] = {4'h0, a[8], 3'b010};
    tx[1] = a[7:0];
    tx[2] = d;
    if (ok) wq.push_back({a, d});
    u_host.frame(tx, 3, rx);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] d);
    tx[0] = {4'h0, a[8], 3'b011};
    tx[1] = a[7:0];
    tx[2] = 8'($urandom);
    u_host.frame(tx, 3, rx);
    check(17'(rx), 17'(d));
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [8:0] a;
    logic [7:0] d;
    void'($urandom(76));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(17'(write_permit_q), 17'h0);
    stat(8'h00);
    wr(9'h155, 8'h5a, 1'b0);
    cmd1(8'h06);
    check(17'(write_permit_q), 17'h1);
    stat(8'h02);
    // Array corners of both halves, then random places
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? {i[0], {8{i[1]}}} : 9'($urandom);
      d = 8'($urandom);
      cmd1(8'h06);
      wr(a, d, 1'b1);
      check(17'(write_permit_q), 17'(a[8]));
      if (a[8]) begin
        wr({1'b0, ~a[7:0]}, ~d, 1'b1);
        check(17'(write_permit_q), 17'h0);
      end
      cmd1(8'h04);
      rd(a, d);
    end
    cmd1(8'h06);
    cmd1(8'h04);
    check(17'(write_permit_q), 17'h0);
    wr(9'h0a5, 8'h3c, 1'b0);
    // Status writes: only the protect selects take, latch clears after
    cmd1(8'h06);
    wst(8'hff);
    check(17'(protect_sel_q), 17'h3);
    stat(8'h0c);
    wst(8'h00);
    stat(8'h0c);
    cmd1(8'h06);
    wr(9'h1a5, 8'hc3, 1'b1);
    wst(8'h00);
    check(17'(protect_sel_q), 17'h0);
    stat(8'h00);
    // Array stalls through a long frame until bytes are lost
    stall <= 1'b1;
    lax <= 1'b1;
    cmd1(8'h06);
    tx[0] = 8'h02;
    tx[1] = 8'h00;
    for (int j = 0; j < 12; j++) begin
      tx[2 + j] = 8'(j);
      if (j < 10) wq.push_back({9'(j), 8'(j)});
    end
    u_host.frame(tx, 14, rx);
    check(17'(wr_overrun_q), 17'h1);
    stall <= 1'b0;
    for (int k = 0; k < 400 && mem_wr_valid_q; k++) @(posedge clk);
    check(17'(wq.size()), 17'h0);
    lax <= 1'b0;
    cmd1(8'h04);
    complete_run();
  end
endmodule
